// ### design/sbcd_top.sv
// scan buffer configuration decoder: layout register, data buffer and scan write sequencing
//
// Contract
// - full 1024-word buffer always host accessible
// - buffer size sets locations one scan updates
// - block 1 takes channel from low six bits
// - block 8 groups aligned on multiples of eight
// - blocks 16, 32, 64 use aligned channel ranges
// - group index from low three bits
// - codes 0 to 2 give 16-word layouts
// - codes 3 to 6 give 32-word layouts
// - codes 7 to 11 give 64-word layouts
// - code 12 is 128 words, one channel
// - source, gain, scan mode fields fixed position
// - don't-care bits never affect scanning
// - layout code bits 15:11, group bits 5:0
// - layout register at 0x0004, byte or word
`timescale 1ns/100ps
module sbcd_top
  import sbcd_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // host register port
  input wire logic host_sel,
  input wire logic host_we,
  input wire logic [1:0] host_be,
  input wire logic [11:0] host_addr,
  input wire logic [15:0] host_wdata,
  output logic host_ack_q,
  output logic [15:0] host_rdata_q,
  // converter side
  input wire logic scan_trigger,
  input wire logic conv_done,
  input wire logic [15:0] conv_data,
  output logic conv_start_q,
  output logic [5:0] conv_chan_q,
  // configuration fields passed on
  output logic irq_origin_select_q,
  output logic [1:0] gain_mode_q,
  output logic [1:0] scan_mode_q,
  // status
  output logic scan_busy_q,
  output logic layout_bad_q
);
  import sbcd_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [15:0] cfg;                // acquisition_layout_setup
    logic [15:0] rdata;              // host read data
    logic ack;                       // host answer strobe
    logic pend;                      // host access in flight
    logic buf_rd;                    // in-flight access hit the buffer
    logic cfg_rd;                    // in-flight access hit the layout register
    sbcd_scan_e st;                  // scan engine state
    logic [SBCD_BUF_AW-1:0] ptr;     // next buffer location of the scan
    logic [5:0] off;                 // channel offset inside the block
    logic req;                       // conversion request
    logic [5:0] chan;                // channel being converted
    logic bad;                       // last trigger refused
    logic busy;                      // scan engine not idle
  } sbcd_state_s;

  sbcd_state_s s_q; // registered state
  sbcd_state_s s_d; // next state

  // ************************************************************
  // layout decode and buffer
  // ************************************************************
  logic [3:0] buf_log2;               // log2 of programmed buffer size
  sbcd_blk_e blk;                     // programmed block size
  logic [5:0] base_chan;              // first channel of active group
  logic layout_ok;                    // code legal for starting a scan
  logic [15:0] mem_rdata;             // buffer read data, one cycle after request
  logic taken;                        // host request accepted this cycle
  logic hit_cfg;                      // request addresses the layout register
  logic hit_buf;                      // request addresses the data buffer
  logic [11:0] buf_ofs;               // byte offset inside the buffer
  logic [SBCD_BUF_AW-1:0] last_loc;   // last location a scan updates
  logic random_mode;                  // random access scan mode
  logic scan_we;                      // scan writes a conversion

  sbcd_layout_decode u_decode (
    .cfg(s_q.cfg),
    .buf_log2(buf_log2),
    .blk(blk),
    .base_chan(base_chan),
    .layout_ok(layout_ok)
  );

  sbcd_buffer_mem #(
    .DATA_W(16),
    .DEPTH(SBCD_BUF_WORDS),
    .AW(SBCD_BUF_AW)
  ) u_buffer (
    .sys_clk(sys_clk),
    .a_en(taken && hit_buf),
    .a_we(host_we),
    .a_be(host_be),
    .a_addr(buf_ofs[SBCD_BUF_AW:1]),
    .a_wdata(host_wdata),
    .a_rdata(mem_rdata),
    .b_we(scan_we),
    .b_addr(s_q.ptr),
    .b_wdata(conv_data)
  );

  // ************************************************************
  // address decode
  // ************************************************************
  // host may reach every buffer word whatever the layout
  always_comb begin
    // a request still held on its answer cycle is not taken a second time
    taken = host_sel && !s_q.pend && !s_q.ack;
    buf_ofs = host_addr - SBCD_BUF_FIRST;
    hit_cfg = 1'b0;
    hit_buf = 1'b0;
    if (host_addr[11:1] == SBCD_CFG_OFS[11:1]) begin
      hit_cfg = 1'b1;
    end else if (host_addr >= SBCD_BUF_FIRST && host_addr <= SBCD_BUF_LAST) begin
      hit_buf = 1'b1;
    end
  end

  // scan bounds taken from the live decode
  always_comb begin
    last_loc = SBCD_BUF_AW'((11'h001 << buf_log2) - 11'h001);
    random_mode = s_q.cfg[SBCD_SMODE_HI];
    scan_we = (s_q.st == SBCD_WAIT) && conv_done;
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    s_d = s_q;
    s_d.ack = 1'b0;
    s_d.req = 1'b0;
    // host answer one cycle after the buffer read data appears
    if (s_q.pend) begin
      s_d.pend = 1'b0;
      s_d.ack = 1'b1;
      if (s_q.buf_rd) begin
        s_d.rdata = mem_rdata;
      end else if (s_q.cfg_rd) begin
        s_d.rdata = s_q.cfg;
      end else begin
        s_d.rdata = 16'h0000; // unmapped reads as zero
      end
    end
    // accept a request; layout register writes honour byte lanes
    if (taken) begin
      s_d.pend = 1'b1;
      s_d.buf_rd = hit_buf;
      s_d.cfg_rd = hit_cfg;
      if (hit_cfg && host_we) begin
        if (host_be[1]) begin
          s_d.cfg[15:8] = host_wdata[15:8];
        end
        if (host_be[0]) begin
          s_d.cfg[7:0] = host_wdata[7:0];
        end
      end
    end
    // scan engine
    case (s_q.st)
      SBCD_IDLE: begin
        if (scan_trigger) begin
          if (!layout_ok) begin
            s_d.bad = 1'b1;
          end else begin
            s_d.bad = 1'b0;
            s_d.ptr = '0;
            s_d.off = 6'h00;
            s_d.st = SBCD_CONVERT;
          end
        end
      end
      SBCD_CONVERT: begin
        // random access converts the selected channel into location 0
        s_d.req = 1'b1;
        if (random_mode) begin
          s_d.chan = s_q.cfg[SBCD_GRP_HI:SBCD_GRP_LO];
        end else begin
          s_d.chan = base_chan | s_q.off;
        end
        s_d.st = SBCD_WAIT;
      end
      SBCD_WAIT: begin
        if (conv_done) begin
          if (random_mode) begin
            s_d.st = SBCD_IDLE;
          end else if (s_q.ptr >= last_loc) begin
            // auto scan re-arms at once, single scan waits for a trigger
            s_d.ptr = '0;
            s_d.off = 6'h00;
            s_d.st = s_q.cfg[SBCD_SMODE_LO] ? SBCD_IDLE : SBCD_CONVERT;
          end else begin
            s_d.ptr = s_q.ptr + SBCD_BUF_AW'(1);
            s_d.off = (s_q.off >= sbcd_blk_last(blk)) ? 6'h00 : s_q.off + 6'h01;
            s_d.st = SBCD_CONVERT;
          end
        end
      end
      default: begin
        s_d.st = SBCD_IDLE;
      end
    endcase
    // busy flag registered alongside the state it mirrors
    s_d.busy = (s_d.st != SBCD_IDLE);
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_q <= '{cfg: SBCD_CFG_RST, rdata: 16'h0000, st: SBCD_IDLE, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // ************************************************************
  // outputs, all from the state register
  // ************************************************************
  assign host_ack_q = s_q.ack;
  assign host_rdata_q = s_q.rdata;
  assign conv_start_q = s_q.req;
  assign conv_chan_q = s_q.chan;
  assign irq_origin_select_q = s_q.cfg[SBCD_IRQ_SRC_BIT];
  assign gain_mode_q = s_q.cfg[SBCD_GAIN_HI:SBCD_GAIN_LO];
  assign scan_mode_q = s_q.cfg[SBCD_SMODE_HI:SBCD_SMODE_LO];
  assign scan_busy_q = s_q.busy;
  assign layout_bad_q = s_q.bad;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_cfg_word_write: assert property (
    taken && hit_cfg && host_we && host_be == 2'h3 |=> s_q.cfg == $past(host_wdata))
    else $error("layout register did not take a word write");

  a_host_ack_delay: assert property (
    taken |-> !host_ack_q ##1 !host_ack_q ##1 host_ack_q)
    else $error("host answer not two cycles after request");

  a_blk8_group: assert property (
    conv_start_q && $past(blk == SBCD_BLK8 && !random_mode) |-> conv_chan_q[5:3] == $past(s_q.cfg[2:0]))
    else $error("block 8 group not aligned on low three bits");

  a_blk16_group: assert property (
    conv_start_q && $past(blk == SBCD_BLK16 && !random_mode) |-> conv_chan_q[5:4] == $past(s_q.cfg[2:1]))
    else $error("block 16 group wrong");

  a_auto_rearm: assert property (
    s_q.st == SBCD_WAIT && conv_done && !random_mode && !s_q.cfg[SBCD_SMODE_LO] && s_q.ptr >= last_loc
      |=> s_q.st == SBCD_CONVERT && s_q.ptr == '0)
    else $error("auto scan did not restart at location 0");

  a_code16_map: assert property (
    s_q.cfg[15:11] == 5'h01 |-> buf_log2 == 4'h4 && blk == SBCD_BLK8)
    else $error("code 1 not 16 words block 8");

  a_code32_map: assert property (
    s_q.cfg[15:11] == 5'h06 |-> buf_log2 == 4'h5 && blk == SBCD_BLK32 && base_chan[4:0] == 5'h00)
    else $error("code 6 not 32 words block 32");

  a_code64_map: assert property (
    s_q.cfg[15:11] == 5'h0B |-> buf_log2 == 4'h6 && blk == SBCD_BLK64 && base_chan == 6'h00)
    else $error("code 11 not 64 words block 64");

  a_code128_chan: assert property (
    s_q.cfg[15:11] == 5'h0C |-> buf_log2 == 4'h7 && base_chan == s_q.cfg[5:0])
    else $error("code 12 not 128 words single channel");

  a_gain_follow: assert property (
    taken && hit_cfg && host_we && host_be[1] |=> gain_mode_q == $past(host_wdata[9:8]))
    else $error("gain field did not follow write");

  a_scan_first_loc: assert property (
    s_q.st == SBCD_IDLE && scan_trigger && layout_ok |-> ##2 conv_start_q && s_q.ptr == '0)
    else $error("scan did not start at location 0");

  a_bad_no_start: assert property (
    s_q.st == SBCD_IDLE && scan_trigger && !layout_ok |=> !scan_busy_q && layout_bad_q)
    else $error("illegal layout started a scan");

  a_ptr_in_buf: assert property (
    scan_busy_q && !random_mode |-> s_q.ptr <= last_loc)
    else $error("scan wrote beyond programmed buffer size");

endmodule : sbcd_top

// ### inc/sbcd_pkg.sv
// shared constants and types of the scan buffer configuration decoder
package sbcd_pkg;

  // ************************************************************
  // register map (byte addresses in the board register space)
  // ************************************************************
  localparam logic [11:0] SBCD_CFG_OFS = 12'h004;   // acquisition_layout_setup
  localparam logic [11:0] SBCD_BUF_FIRST = 12'h080; // first data buffer byte
  localparam logic [11:0] SBCD_BUF_LAST = 12'h87F;  // last data buffer byte
  localparam logic [15:0] SBCD_CFG_RST = 16'h0000;  // 16 words, channel 0, auto scan, gain x1

  // ************************************************************
  // field positions of acquisition_layout_setup
  // ************************************************************
  localparam int SBCD_LAYOUT_HI = 15;   // buffer-layout code
  localparam int SBCD_LAYOUT_LO = 11;
  localparam int SBCD_IRQ_SRC_BIT = 10; // irq_origin_select
  localparam int SBCD_GAIN_HI = 9;      // gain mode
  localparam int SBCD_GAIN_LO = 8;
  localparam int SBCD_SMODE_HI = 7;     // scan mode
  localparam int SBCD_SMODE_LO = 6;
  localparam int SBCD_GRP_HI = 5;       // channel or group select
  localparam int SBCD_GRP_LO = 0;

  // ************************************************************
  // buffer and layout code constants
  // ************************************************************
  localparam int SBCD_BUF_WORDS = 1024;              // whole data buffer
  localparam int SBCD_BUF_AW = 10;                   // word address width
  localparam logic [4:0] SBCD_CODE_BUF32 = 5'h03;    // first code of 32-word layouts
  localparam logic [4:0] SBCD_CODE_BUF64 = 5'h07;    // first code of 64-word layouts
  localparam logic [4:0] SBCD_CODE_BUF128 = 5'h0C;   // first code of 128-word layouts
  localparam logic [4:0] SBCD_CODES_PER_BUF = 5'h05; // block sizes per larger buffer
  localparam logic [3:0] SBCD_LOG2_BUF16 = 4'h4;     // log2 of 16 words
  localparam logic [3:0] SBCD_LOG2_BUF32 = 4'h5;
  localparam logic [3:0] SBCD_LOG2_BUF64 = 4'h6;
  localparam logic [3:0] SBCD_LOG2_BUF128 = 4'h7;

  // block sizes in code order
  typedef enum logic [2:0] {SBCD_BLK1, SBCD_BLK8, SBCD_BLK16, SBCD_BLK32, SBCD_BLK64} sbcd_blk_e;

  // scan engine states
  typedef enum logic [1:0] {SBCD_IDLE, SBCD_CONVERT, SBCD_WAIT} sbcd_scan_e;

  // channels per block, minus one
  function automatic logic [5:0] sbcd_blk_last(input sbcd_blk_e blk);
    logic [5:0] n;
    n = 6'h00;
    case (blk)
      SBCD_BLK8: n = 6'h07;
      SBCD_BLK16: n = 6'h0F;
      SBCD_BLK32: n = 6'h1F;
      SBCD_BLK64: n = 6'h3F;
      default: n = 6'h00;
    endcase
    return n;
  endfunction : sbcd_blk_last

endpackage : sbcd_pkg

// ### design/sbcd_buffer_mem.sv
// dual port data buffer: host read/write port and scan write port
`timescale 1ns/100ps
module sbcd_buffer_mem #(
  parameter int DATA_W = 16,
  parameter int DEPTH = 1024,
  parameter int AW = 10
) (
  // clock
  input wire logic sys_clk,
  // host port
  input wire logic a_en,
  input wire logic a_we,
  input wire logic [DATA_W/8-1:0] a_be,
  input wire logic [AW-1:0] a_addr,
  input wire logic [DATA_W-1:0] a_wdata,
  output logic [DATA_W-1:0] a_rdata,
  // scan port
  input wire logic b_we,
  input wire logic [AW-1:0] b_addr,
  input wire logic [DATA_W-1:0] b_wdata
);

  logic [DATA_W-1:0] mem [DEPTH]; // storage, no reset

  // read data registered; scan write lands last so it wins a same-word clash
  always_ff @(posedge sys_clk) begin
    if (a_en) begin
      a_rdata <= mem[a_addr];
    end
    for (int i = 0; i < DATA_W / 8; i++) begin
      if (a_en && a_we && a_be[i]) begin
        mem[a_addr][i*8+:8] <= a_wdata[i*8+:8];
      end
    end
    if (b_we) begin
      mem[b_addr] <= b_wdata;
    end
  end

endmodule : sbcd_buffer_mem

// ### design/sbcd_layout_decode.sv
// decodes the layout code and group field into buffer size, block size and first channel
`timescale 1ns/100ps
module sbcd_layout_decode
  import sbcd_pkg::*;
(
  // configuration word
  input wire logic [15:0] cfg,
  // decoded layout
  output logic [3:0] buf_log2,
  output sbcd_blk_e blk,
  output logic [5:0] base_chan,
  output logic layout_ok
);

  logic [4:0] code; // layout code
  logic [4:0] rel;  // code relative to the 128-word group
  logic [4:0] idx;  // block size index inside its buffer size

  // buffer size, block size and legality
  always_comb begin
    code = cfg[SBCD_LAYOUT_HI:SBCD_LAYOUT_LO];
    rel = 5'h00;
    if (code < SBCD_CODE_BUF32) begin
      buf_log2 = SBCD_LOG2_BUF16;
      idx = code;
    end else if (code < SBCD_CODE_BUF64) begin
      buf_log2 = SBCD_LOG2_BUF32;
      idx = code - SBCD_CODE_BUF32;
    end else if (code < SBCD_CODE_BUF128) begin
      buf_log2 = SBCD_LOG2_BUF64;
      idx = code - SBCD_CODE_BUF64;
    end else begin
      rel = code - SBCD_CODE_BUF128;
      buf_log2 = SBCD_LOG2_BUF128 + 4'(rel / SBCD_CODES_PER_BUF);
      idx = rel % SBCD_CODES_PER_BUF;
    end
    blk = sbcd_blk_e'(idx[2:0]);
    // a block larger than the buffer allows never starts a scan
    if (buf_log2 == SBCD_LOG2_BUF16) begin
      layout_ok = (idx <= 5'(SBCD_BLK16));
    end else if (buf_log2 == SBCD_LOG2_BUF32) begin
      layout_ok = (idx <= 5'(SBCD_BLK32));
    end else begin
      layout_ok = (idx <= 5'(SBCD_BLK64));
    end
  end

  // first channel of the active group; unused group bits are masked off
  always_comb begin
    case (blk)
      SBCD_BLK1: base_chan = cfg[SBCD_GRP_HI:SBCD_GRP_LO];
      SBCD_BLK8: base_chan = {cfg[2:0], 3'h0};
      SBCD_BLK16: base_chan = {cfg[2:1], 4'h0};
      SBCD_BLK32: base_chan = {cfg[2], 5'h00};
      default: base_chan = 6'h00;
    endcase
  end

endmodule : sbcd_layout_decode

// ### bench/sbcd_host_model.sv
// host processor model: layout register and data buffer accesses
`timescale 1ns/100ps
module sbcd_host_model (
  // clock
  input wire logic sys_clk,
  // request lines
  output logic host_sel,
  output logic host_we,
  output logic [1:0] host_be,
  output logic [11:0] host_addr,
  output logic [15:0] host_wdata,
  // answer lines
  input wire logic host_ack_q,
  input wire logic [15:0] host_rdata_q
);
  // ************************************************************
  // idle bus
  // ************************************************************
  initial begin
    host_sel = 1'b0;
    host_we = 1'b0;
    host_be = 2'b00;
    host_addr = 12'h000;
    host_wdata = 16'h0000;
  end

  // ************************************************************
  // one access, held until the edge that samples the answer
  // ************************************************************
  task automatic access(input logic we, input logic [1:0] be, input logic [11:0] addr,
                        input logic [15:0] wdata, output logic [15:0] rdata, output logic ok);
    int n;
    ok = 1'b0;
    rdata = 16'h0000;
    @(negedge sys_clk);
    host_sel = 1'b1;
    host_we = we;
    host_be = be;
    host_addr = addr;
    host_wdata = wdata;
    for (n = 0; n < 8 && ok == 1'b0; n++) begin
      @(posedge sys_clk);
      if (host_ack_q === 1'b1) begin
        ok = 1'b1;
        rdata = host_rdata_q;
      end
    end
    @(negedge sys_clk);
    host_sel = 1'b0;
    // released we, address and data lines must not keep the old value; byte enables keep theirs
    host_we = ~we;
    host_addr = ~addr;
    host_wdata = ~wdata;
    // keep consecutive requests apart
    repeat (2) @(posedge sys_clk);
  endtask : access
endmodule : sbcd_host_model

// ### bench/sbcd_top_tb.sv
// self-checking bench of the scan buffer configuration decoder
`timescale 1ns/100ps
module sbcd_top_tb;
  import sbcd_pkg::*;
  // clock, reset and converter lines
  logic sys_clk, rst, scan_trigger, conv_done;
  logic [15:0] conv_data;
  // host lines
  logic host_sel, host_we, host_ack_q;
  logic [1:0] host_be;
  logic [11:0] host_addr;
  logic [15:0] host_wdata, host_rdata_q;
  // design outputs
  logic conv_start_q, irq_origin_select_q, scan_busy_q, layout_bad_q;
  logic [5:0] conv_chan_q;
  logic [1:0] gain_mode_q, scan_mode_q;
  // counters
  int mismatches, cmp_count;
  // layout table: config word, conversions, block, first channel
  logic [15:0] cfg_tab [14] = '{16'h046A, 16'h097F, 16'h127D, 16'h1845, 16'h2049, 16'h2F73, 16'h307C,
                               16'h387F, 16'h4042, 16'h4846, 16'h507B, 16'h5855, 16'h6051, 16'h0087};
  int n_tab [14] = '{16, 16, 16, 32, 32, 32, 32, 64, 64, 64, 64, 64, 128, 1};
  int blk_tab [14] = '{1, 8, 16, 1, 8, 16, 32, 1, 8, 16, 32, 64, 1, 1};
  int base_tab [14] = '{42, 56, 32, 5, 8, 16, 32, 63, 16, 48, 0, 0, 17, 7};

  // ************************************************************
  // design and host model
  // ************************************************************
  sbcd_top i_sbcd_top (.sys_clk(sys_clk), .rst(rst), .host_sel(host_sel), .host_we(host_we),
    .host_be(host_be), .host_addr(host_addr), .host_wdata(host_wdata), .host_ack_q(host_ack_q),
    .host_rdata_q(host_rdata_q), .scan_trigger(scan_trigger), .conv_done(conv_done),
    .conv_data(conv_data), .conv_start_q(conv_start_q), .conv_chan_q(conv_chan_q),
    .irq_origin_select_q(irq_origin_select_q), .gain_mode_q(gain_mode_q),
    .scan_mode_q(scan_mode_q), .scan_busy_q(scan_busy_q), .layout_bad_q(layout_bad_q));
  sbcd_host_model i_sbcd_host_model (.sys_clk(sys_clk), .host_sel(host_sel), .host_we(host_we),
    .host_be(host_be), .host_addr(host_addr), .host_wdata(host_wdata), .host_ack_q(host_ack_q),
    .host_rdata_q(host_rdata_q));

  // ************************************************************
  // clock
  // ************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // ************************************************************
  // helpers
  // ************************************************************
  // compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // verdict and end of run
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out

  // a wait that ran out
  task automatic hung();
    mismatches++;
    $display("[ERR] t=%0t seen=%h exp=%h", $time, 1'b0, 1'b1);
    close_out();
  endtask : hung

  // host access through the model
  task automatic acc(input logic we, input logic [1:0] be, input logic [11:0] a,
                     input logic [15:0] d, output logic [15:0] r);
    logic ok;
    i_sbcd_host_model.access(we, be, a, d, r, ok);
    if (ok !== 1'b1) hung();
  endtask : acc

  // ************************************************************
  // scenarios
  // ************************************************************
  // reset values, unmapped place, buffer ends, byte lanes
  task automatic t_regs();
    logic [15:0] r;
    chk({1'b0, host_ack_q, conv_start_q, scan_busy_q, layout_bad_q, irq_origin_select_q,
         gain_mode_q, scan_mode_q, conv_chan_q}, 16'h0000);
    acc(1'b0, 2'b11, SBCD_CFG_OFS, 16'h0000, r);
    chk(r, SBCD_CFG_RST);
    acc(1'b0, 2'b11, 12'h010, 16'h0000, r);
    chk(r, 16'h0000);
    acc(1'b1, 2'b11, SBCD_BUF_FIRST, 16'h1234, r);
    acc(1'b1, 2'b11, 12'h87E, 16'h4321, r);
    acc(1'b0, 2'b11, SBCD_BUF_FIRST, 16'h0000, r);
    chk(r, 16'h1234);
    acc(1'b0, 2'b11, 12'h87E, 16'h0000, r);
    chk(r, 16'h4321);
    acc(1'b1, 2'b01, SBCD_CFG_OFS, 16'hFFFF, r);
    acc(1'b1, 2'b10, SBCD_CFG_OFS, 16'h5A00, r);
    acc(1'b0, 2'b11, SBCD_CFG_OFS, 16'h0000, r);
    chk(r, 16'h5AFF);
    chk({11'h000, irq_origin_select_q, gain_mode_q, scan_mode_q}, 16'h000B);
    $display("test regs done");
  endtask : t_regs

  // one layout: channel order, locations filled, marker past the end kept
  task automatic t_scan(input logic [15:0] cfg, input int n, input int blk, input int base);
    logic [15:0] r;
    int k, w;
    acc(1'b1, 2'b11, SBCD_CFG_OFS, cfg, r);
    chk({11'h000, irq_origin_select_q, gain_mode_q, scan_mode_q}, {11'h000, cfg[10:6]});
    acc(1'b1, 2'b11, SBCD_BUF_FIRST + 12'(2 * n), 16'hBEEF, r);
    @(negedge sys_clk);
    scan_trigger = 1'b1;
    @(negedge sys_clk);
    scan_trigger = 1'b0;
    for (k = 0; k < n; k++) begin
      w = 0;
      while (conv_start_q !== 1'b1 && w < 20) begin
        @(negedge sys_clk);
        w++;
      end
      if (w == 20) hung();
      chk({10'h000, conv_chan_q}, 16'(base + k % blk));
      // converter answers after one to three cycles
      repeat (1 + k % 3) @(negedge sys_clk);
      conv_done = 1'b1;
      conv_data = 16'hC000 ^ 16'(k);
      @(negedge sys_clk);
      conv_done = 1'b0;
      conv_data = ~conv_data;
    end
    w = 0;
    while (scan_busy_q !== 1'b0 && w < 20) begin
      @(negedge sys_clk);
      w++;
    end
    if (w == 20) hung();
    acc(1'b0, 2'b11, SBCD_BUF_FIRST, 16'h0000, r);
    chk(r, 16'hC000);
    acc(1'b0, 2'b11, SBCD_BUF_FIRST + 12'(2 * (n - 1)), 16'h0000, r);
    chk(r, 16'hC000 ^ 16'(n - 1));
    acc(1'b0, 2'b11, SBCD_BUF_FIRST + 12'(2 * n), 16'h0000, r);
    chk(r, 16'hBEEF);
    $display("test scan cfg=%h done", cfg);
  endtask : t_scan

  // auto scan wraps to location 0 and goes on; reset in mid-scan restores defaults
  task automatic t_auto();
    logic [15:0] r;
    int k, w;
    acc(1'b1, 2'b11, SBCD_CFG_OFS, 16'h0003, r);
    @(negedge sys_clk);
    scan_trigger = 1'b1;
    @(negedge sys_clk);
    scan_trigger = 1'b0;
    for (k = 0; k < 17; k++) begin
      w = 0;
      while (conv_start_q !== 1'b1 && w < 20) begin
        @(negedge sys_clk);
        w++;
      end
      if (w == 20) hung();
      chk({10'h000, conv_chan_q}, 16'h0003);
      @(negedge sys_clk);
      conv_done = 1'b1;
      conv_data = 16'hA000 ^ 16'(k);
      @(negedge sys_clk);
      conv_done = 1'b0;
    end
    chk({15'h0000, scan_busy_q}, 16'h0001);
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    chk({1'b0, host_ack_q, conv_start_q, scan_busy_q, layout_bad_q, irq_origin_select_q,
         gain_mode_q, scan_mode_q, conv_chan_q}, 16'h0000);
    acc(1'b0, 2'b11, SBCD_CFG_OFS, 16'h0000, r);
    chk(r, SBCD_CFG_RST);
    acc(1'b0, 2'b11, SBCD_BUF_FIRST, 16'h0000, r);
    chk(r, 16'hA010);
    $display("test auto done");
  endtask : t_auto

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    rst = 1'b1;
    scan_trigger = 1'b0;
    conv_done = 1'b0;
    conv_data = 16'h0000;
    mismatches = 0;
    cmp_count = 0;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    t_regs();
    // host writes only block sizes its buffer size allows
    for (int i = 0; i < 14; i++) begin
      t_scan(cfg_tab[i], n_tab[i], blk_tab[i], base_tab[i]);
    end
    t_auto();
    close_out();
  end
endmodule : sbcd_top_tb
